/* gfv_defs.vh */
/*
 * Constants for the gas flow valve selector: code widths, the forced
 * default used with an exchanger, and a synchroniser reset level.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef GFV_DEFS_VH
`define GFV_DEFS_VH

`define GFV_CODE_W      4
`define GFV_CODE_CLOSED 4'h0
`define GFV_CODE_OPEN   4'hf
`define GFV_BIT_A       3
`define GFV_BIT_B       2
`define GFV_BIT_C       1
`define GFV_BIT_D       0
`define GFV_RST_CODE    4'h0
`define GFV_SYNC_RST    1'b0

`endif

/* gfv_sync.v */
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes a synchronous active-low reset on the sampling clock.
 */
`include "gfv_defs.vh"

module gfv_sync (
    input  wire clk,      // Sampling clock
    input  wire rst_n,    // Synchronous reset, active low
    input  wire rst_val,  // Value held during reset
    input  wire d_async,  // Asynchronous level
    output wire q_sync    // Synchronised level
);

    reg meta_r;
    reg sync_r;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_n) begin
            // Reset to the idle level so release shows no false edge
            meta_r <= rst_val;
            sync_r <= rst_val;
        end else begin
            meta_r <= d_async;
            sync_r <= meta_r;
        end
    end

    assign q_sync = rst_n ? sync_r : rst_val;

endmodule

/* gfv_valve_drive.v */
/*
 * Valve driver: registers each code bit onto its own valve output.
 * Assumes a synchronous active-low reset; valves closed in reset.
 */
`include "gfv_defs.vh"

module gfv_valve_drive (
    input  wire                   clk,    // System clock
    input  wire                   rst_n,  // Synchronous reset, active low
    input  wire [`GFV_CODE_W-1:0] code,   // Code to apply
    output wire [`GFV_CODE_W-1:0] valve   // One open level per valve
);

    reg [`GFV_CODE_W-1:0] valve_r;

    // One flip-flop per valve, all valves in parallel
    genvar i;
    generate
        for (i = 0; i < `GFV_CODE_W; i = i + 1) begin : g_valve
            always @(posedge clk) begin
                if (!rst_n) begin
                    valve_r[i] <= 1'b0;
                end else begin
                    valve_r[i] <= code[i];
                end
            end
        end
    endgenerate

    assign valve = valve_r;

endmodule

/* gfv_selector.v */
/*
 * Gas flow valve selector top: picks default or software code, drives
 * four valves, watches the flow detector and gates the heater.
 *
 * Timing after reset release (edge 1 is the first edge with RST_N high):
 * the strap synchronisers are full after edge 2, the strap word is
 * caught at edge 3 and the default code is in force from edge 4.
 * A software write shows in SW_CODE_HELD one edge later; with the
 * heater on it reaches APPLIED_CODE one edge after that and the valves
 * one edge later still. A pin change on the flow or exchanger inputs
 * takes three edges to reach FLOW_MISSING, HEATER_ON or DEFAULT_CODE.
 * Straps are read once; moving a strap takes effect after a reset.
 *
 * Assumes straps and detector pins are asynchronous and static straps
 * settle before reset release; software inputs are on CLOCK.
 */
// How it works
// - Four valve outputs follow a four-bit code; 0000 closes all, 1111 opens.
// - Each code bit opens or closes its own valve; valves act in parallel.
// - At power-on the default code is captured from the hardware straps.
// - With the heater off the valves follow the default code.
// - Every software code write is stored regardless of heater state.
// - Stored software code reaches valves only once the heater is on.
// - While heater is on a new software code applies immediately.
// - Heater turning off returns the valves to the default code.
// - A connected exchanger forces the default code to zero.
// - Detector reporting no flow raises the missing-flow indication.
// - Missing flow forces the probe heater power off.
// - Gas cooler enable follows the heater on state.
`include "gfv_defs.vh"

module gfv_selector (
    input  wire                   CLOCK,             // 125 MHz clock
    input  wire                   RST_N,             // Sync reset, low
    input  wire [`GFV_CODE_W-1:0] DEFAULT_FLOW_STRAP, // Strap pins
    input  wire                   EXCH_DETECT_N,     // Exchanger, low
    input  wire                   FLOW_PRESENT,      // Detector, high=flow
    input  wire                   HEATER_REQ,        // Heater on request
    input  wire                   SW_CODE_WR,        // Code write strobe
    input  wire [`GFV_CODE_W-1:0] SW_CODE,           // Requested code
    output wire [`GFV_CODE_W-1:0] VALVE_OPEN,        // Valve A..D drive
    output reg  [`GFV_CODE_W-1:0] APPLIED_CODE,      // Code now applied
    output reg  [`GFV_CODE_W-1:0] SW_CODE_HELD,      // Stored request
    output reg  [`GFV_CODE_W-1:0] DEFAULT_CODE,      // Default in force
    output reg                    FLOW_MISSING,      // No gas flow
    output reg                    HEATER_ON,         // Heater power on
    output reg                    GAS_COOLER_ENABLE  // Cooler run
);

    // Phases of power-on; SETTLE lets the strap synchronisers fill
    localparam PH_RESET   = 2'b00;
    localparam PH_SETTLE  = 2'b01;
    localparam PH_CAPTURE = 2'b10;
    localparam PH_RUN     = 2'b11;

    reg  [1:0]             phase_r;
    reg  [1:0]             phase_nxt;
    reg  [`GFV_CODE_W-1:0] strap_r;
    reg  [`GFV_CODE_W-1:0] code_nxt;
    wire [`GFV_CODE_W-1:0] strap_s;
    wire                   exch_n_s;
    wire                   flow_s;
    wire                   exch_present;
    wire                   heater_nxt;

    // Strap pins through synchronisers
    genvar k;
    generate
        for (k = 0; k < `GFV_CODE_W; k = k + 1) begin : g_strap
            gfv_sync u_sync (
                .clk     (CLOCK),
                .rst_n   (RST_N),
                .rst_val (1'b0),
                .d_async (DEFAULT_FLOW_STRAP[k]),
                .q_sync  (strap_s[k])
            );
        end
    endgenerate

    // Exchanger detect, idles high (absent)
    gfv_sync u_sync_exch (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .rst_val (1'b1),
        .d_async (EXCH_DETECT_N),
        .q_sync  (exch_n_s)
    );

    // Flow detector, idles high (flow assumed) during reset and until edge 2 after release
    gfv_sync u_sync_flow (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .rst_val (1'b1),
        .d_async (FLOW_PRESENT),
        .q_sync  (flow_s)
    );

    assign exch_present = ~exch_n_s;

    // Phase sequencing: wait for the synchronisers, then capture
    always @* begin
        case (phase_r)
            PH_RESET:   phase_nxt = PH_SETTLE;
            PH_SETTLE:  phase_nxt = PH_CAPTURE;
            PH_CAPTURE: phase_nxt = PH_RUN;
            PH_RUN:     phase_nxt = PH_RUN;
            default:    phase_nxt = PH_RESET;
        endcase
    end

    always @(posedge CLOCK) begin
        if (!RST_N) begin
            phase_r <= PH_RESET;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Strap value caught once after reset release
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            strap_r <= `GFV_RST_CODE;
        end else if (phase_r == PH_CAPTURE) begin
            strap_r <= strap_s;
        end
    end

    // Default code: zero with exchanger, else the strap value
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            DEFAULT_CODE <= `GFV_RST_CODE;
        end else if (exch_present) begin
            DEFAULT_CODE <= `GFV_CODE_CLOSED;
        end else if (phase_r == PH_RUN) begin
            DEFAULT_CODE <= strap_r;
        end
    end

    // Software request always stored
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            SW_CODE_HELD <= `GFV_RST_CODE;
        end else if (SW_CODE_WR) begin
            SW_CODE_HELD <= SW_CODE;
        end
    end

    // Missing flow flag follows the detector
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            FLOW_MISSING <= 1'b0;
        end else begin
            FLOW_MISSING <= ~flow_s;
        end
    end

    // Heater allowed only while flow present
    assign heater_nxt = HEATER_REQ & flow_s;

    always @(posedge CLOCK) begin
        if (!RST_N) begin
            HEATER_ON         <= 1'b0;
            GAS_COOLER_ENABLE <= 1'b0;
        end else begin
            HEATER_ON         <= heater_nxt;
            GAS_COOLER_ENABLE <= heater_nxt;
        end
    end

    // Code selection: software when heater on, default otherwise
    always @* begin
        if (HEATER_ON) begin
            code_nxt = SW_CODE_HELD;
        end else begin
            code_nxt = DEFAULT_CODE;
        end
    end

    always @(posedge CLOCK) begin
        if (!RST_N) begin
            APPLIED_CODE <= `GFV_RST_CODE;
        end else begin
            APPLIED_CODE <= code_nxt;
        end
    end

    // Per-valve drive from the applied code
    gfv_valve_drive u_drive (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .code  (APPLIED_CODE),
        .valve (VALVE_OPEN)
    );

endmodule

/* gfv_selector_assertions.sv */
/* Checker for the valve selector top ports.
   Assumes one clock and a synchronous active-low reset. */
module gfv_sel_chk (
    input wire       CLOCK,             // System clock
    input wire       RST_N,             // Reset, low
    input wire       EXCH_DETECT_N,     // Exchanger, low
    input wire       FLOW_PRESENT,      // Detector
    input wire       HEATER_REQ,        // Heater request
    input wire       SW_CODE_WR,        // Write strobe
    input wire [3:0] SW_CODE,           // Requested code
    input wire [3:0] VALVE_OPEN,        // Valve drive
    input wire [3:0] APPLIED_CODE,      // Applied code
    input wire [3:0] SW_CODE_HELD,      // Stored request
    input wire [3:0] DEFAULT_CODE,      // Default code
    input wire       FLOW_MISSING,      // No flow
    input wire       HEATER_ON,         // Heater power
    input wire       GAS_COOLER_ENABLE  // Cooler run
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Each valve follows its own code bit one edge later
    property p_valve; 1 |=> VALVE_OPEN == $past(APPLIED_CODE); endproperty
    a_valve: assert property (p_valve) else $error("valve lag");
    property p_held; SW_CODE_WR |=> SW_CODE_HELD == $past(SW_CODE); endproperty
    a_held: assert property (p_held) else $error("write lost");
    property p_on;
        HEATER_ON |=> APPLIED_CODE == $past(SW_CODE_HELD);
    endproperty
    a_on: assert property (p_on) else $error("sw code not applied");
    property p_off;
        !HEATER_ON |=> APPLIED_CODE == $past(DEFAULT_CODE);
    endproperty
    a_off: assert property (p_off) else $error("default not applied");
    property p_cool; GAS_COOLER_ENABLE == HEATER_ON; endproperty
    a_cool: assert property (p_cool) else $error("cooler mismatch");
    property p_miss; !FLOW_PRESENT [*4] |=> FLOW_MISSING; endproperty
    a_miss: assert property (p_miss) else $error("no flow not flagged");
    property p_cut; FLOW_MISSING [*2] |-> !HEATER_ON; endproperty
    a_cut: assert property (p_cut) else $error("heater not cut");
    property p_heat; (HEATER_REQ && FLOW_PRESENT) [*5] |=> HEATER_ON;
    endproperty
    a_heat: assert property (p_heat) else $error("heater not on");
    property p_exch; !EXCH_DETECT_N [*4] |=> DEFAULT_CODE == 4'h0; endproperty
    a_exch: assert property (p_exch) else $error("exch default");
    c_write: cover property (HEATER_ON && SW_CODE_WR);
    c_miss: cover property (FLOW_MISSING && HEATER_REQ);
    c_exch: cover property (!EXCH_DETECT_N && DEFAULT_CODE == 4'h0);
endmodule
bind gfv_selector gfv_sel_chk i_gfv_sel_chk (.CLOCK(CLOCK), .RST_N(RST_N),
    .EXCH_DETECT_N(EXCH_DETECT_N), .FLOW_PRESENT(FLOW_PRESENT),
    .HEATER_REQ(HEATER_REQ), .SW_CODE_WR(SW_CODE_WR), .SW_CODE(SW_CODE),
    .VALVE_OPEN(VALVE_OPEN), .APPLIED_CODE(APPLIED_CODE),
    .SW_CODE_HELD(SW_CODE_HELD), .DEFAULT_CODE(DEFAULT_CODE),
    .FLOW_MISSING(FLOW_MISSING), .HEATER_ON(HEATER_ON),
    .GAS_COOLER_ENABLE(GAS_COOLER_ENABLE));

/* gfv_valve_block.sv */
/* Valve block and optical flow detector model.
   Assumes high-open valves; the bench sets the gas supply. */
module gfv_valve_block (
    input  wire       clk,        // System clock
    input  wire [3:0] valve_open, // Valve drive
    input  wire       supply_on,  // Gas line pressurised
    output reg        flow_seen   // Barrier clear
);
    timeunit 1ns;
    timeprecision 1ps;
    initial flow_seen = 1'b0;
    // Gas reaches the barrier only through an open valve, after a lag
    always @(posedge clk) begin
        flow_seen <= supply_on && (valve_open != 4'h0);
    end
endmodule

/* gfv_selector_test.sv */
/* Self-checking bench for the valve selector.
   Assumes the valve block model drives the detector input. */
module gfv_selector_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, exch_n = 1, heat = 0, wr = 0, sup = 1;
    logic [3:0]  strap = 4'h3, code = 4'h0;
    wire  [3:0]  valve, applied, held, dflt;
    wire         flow, missing, heat_on, cool;
    int          num_errors = 0, n_checks = 0, cycles = 0;
    // Rows: {heat, wr}, code, expected applied, expected held
    logic [15:0] rows [7] = '{16'h1535, 16'h2555, 16'h3fff, 16'h3999,
                              16'h0939, 16'h1636, 16'h2666};
    gfv_selector i_gfv_selector (.CLOCK(clk), .RST_N(rst_n),
        .DEFAULT_FLOW_STRAP(strap), .EXCH_DETECT_N(exch_n),
        .FLOW_PRESENT(flow), .HEATER_REQ(heat), .SW_CODE_WR(wr),
        .SW_CODE(code), .VALVE_OPEN(valve), .APPLIED_CODE(applied),
        .SW_CODE_HELD(held), .DEFAULT_CODE(dflt), .FLOW_MISSING(missing),
        .HEATER_ON(heat_on), .GAS_COOLER_ENABLE(cool));
    gfv_valve_block i_gfv_valve_block (.clk(clk), .valve_open(valve),
        .supply_on(sup), .flow_seen(flow));
    always #4 clk = ~clk;
    task stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task do_reset(input logic [3:0] s);
        strap = s;
        rst_n = 0;
        repeat (6) @(negedge clk);
        check("rst applied", applied, 4'h0);
        rst_n = 1;
        repeat (8) @(negedge clk);
        check("default", dflt, s);
        check("valve", valve, s);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        do_reset(4'h3);
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            {heat, wr} = rows[i][13:12];
            code = rows[i][11:8];
            @(negedge clk);
            wr = 0;
            repeat (6) @(negedge clk);
            check("applied", applied, rows[i][7:4]);
            check("valve", valve, rows[i][7:4]);
            check("held", held, rows[i][3:0]);
            check("cooler", {3'h0, cool}, {3'h0, heat});
        end
        // Back-to-back writes with the heater on
        code = 4'h1;
        wr = 1;
        @(negedge clk);
        code = 4'h2;
        @(negedge clk);
        wr = 0;
        repeat (5) @(negedge clk);
        check("b2b held", held, 4'h2);
        check("b2b valve", valve, 4'h2);
        // Gas supply lost while heating
        sup = 0;
        repeat (10) @(negedge clk);
        check("missing", {3'h0, missing}, 4'h1);
        check("heater cut", {3'h0, heat_on}, 4'h0);
        check("fallback", applied, 4'h3);
        sup = 1;
        heat = 0;
        exch_n = 0;
        repeat (8) @(negedge clk);
        check("exch default", dflt, 4'h0);
        check("exch valve", valve, 4'h0);
        exch_n = 1;
        do_reset(4'ha);
        stop_test();
    end
endmodule
